// File: logic/aedec_table.sv
// Combinational opcode table for multiply, decimal add, swap and add groups
`timescale 1ns/1ps
`default_nettype none
module aedec_table (
    // Opcode in, decode out
    aedec_if.table_side dif
);
    import aedec_pkg::*;

    logic [3:0] line;
    logic [2:0] rx;
    logic [2:0] sreg;
    logic [2:0] opm;
    logic       rm;

    assign line = dif.opcode[AEDEC_LINE_HI:AEDEC_LINE_LO];
    assign rx   = dif.opcode[AEDEC_RX_HI:AEDEC_RX_LO];
    assign sreg = dif.opcode[AEDEC_SRC_HI:AEDEC_SRC_LO];
    assign opm  = dif.opcode[AEDEC_OPM_HI:AEDEC_OPM_LO];
    assign rm   = dif.opcode[AEDEC_RM_BIT];

    always_comb begin
        dif.dec            = '0;
        dif.dec.op         = AEDEC_OP_NONE;
        dif.dec.size       = AEDEC_SZ_WORD;
        dif.dec.first_rf   = AEDEC_RF_NONE;
        dif.dec.second_rf  = AEDEC_RF_NONE;
        dif.dec.first_reg  = rx;
        dif.dec.second_reg = sreg;
        dif.dec.ea         = dif.opcode[AEDEC_EAM_HI:AEDEC_SRC_LO];
        if (line == AEDEC_LINE_MUL) begin
            if (dif.opcode[7:6] == AEDEC_MUL_SEL) begin
                // Type bit picks the signedness; destination is always a data register
                dif.dec.op       = (dif.opcode[AEDEC_TYPE_BIT] == AEDEC_TYPE_UNSIGN) ?
                                   AEDEC_OP_UMUL_W : AEDEC_OP_SMUL_W;
                dif.dec.first_rf = AEDEC_RF_DATA;
                dif.dec.use_ea   = 1'b1;
            end else if (dif.opcode[8:4] == AEDEC_DADD_SEL) begin
                dif.dec.size = AEDEC_SZ_BYTE;
                if (rm == AEDEC_RM_REG) begin
                    dif.dec.op        = AEDEC_OP_DADD_REG;
                    dif.dec.first_rf  = AEDEC_RF_DATA;
                    dif.dec.second_rf = AEDEC_RF_DATA;
                end else begin
                    dif.dec.op        = AEDEC_OP_DADD_MEM;
                    dif.dec.first_rf  = AEDEC_RF_ADDR;
                    dif.dec.second_rf = AEDEC_RF_ADDR;
                    dif.dec.predec    = 1'b1;
                end
            end else if (dif.opcode[AEDEC_OPM_HI:AEDEC_RM_BIT] == AEDEC_SWAP_DD ||
                         dif.opcode[AEDEC_OPM_HI:AEDEC_RM_BIT] == AEDEC_SWAP_AA) begin
                // Same-file swaps differ only in bit 3
                dif.dec.size = AEDEC_SZ_LONG;
                if (rm == AEDEC_RM_REG) begin
                    dif.dec.op        = AEDEC_OP_SWAP_DD;
                    dif.dec.first_rf  = AEDEC_RF_DATA;
                    dif.dec.second_rf = AEDEC_RF_DATA;
                end else begin
                    dif.dec.op        = AEDEC_OP_SWAP_AA;
                    dif.dec.first_rf  = AEDEC_RF_ADDR;
                    dif.dec.second_rf = AEDEC_RF_ADDR;
                end
            end else if (dif.opcode[AEDEC_OPM_HI:AEDEC_RM_BIT] == AEDEC_SWAP_DA) begin
                // Mixed swap is its own encoding, not a variant of the two above
                dif.dec.size      = AEDEC_SZ_LONG;
                dif.dec.op        = AEDEC_OP_SWAP_DA;
                dif.dec.first_rf  = AEDEC_RF_DATA;
                dif.dec.second_rf = AEDEC_RF_ADDR;
            end else begin
                dif.dec.illegal = 1'b1;
            end
        end else if (line == AEDEC_LINE_ADD) begin
            dif.dec.use_ea = 1'b1;
            case (opm)
                AEDEC_OPM_ADD_B, AEDEC_OPM_ADD_W, AEDEC_OPM_ADD_L: begin
                    dif.dec.op       = AEDEC_OP_ADD_DN;
                    dif.dec.size     = aedec_size_t'(opm[1:0]);
                    dif.dec.first_rf = AEDEC_RF_DATA;
                end
                AEDEC_OPM_ADD_AN_W, AEDEC_OPM_ADD_AN_L: begin
                    dif.dec.op       = AEDEC_OP_ADD_AN;
                    dif.dec.size     = opm[2] ? AEDEC_SZ_LONG : AEDEC_SZ_WORD;
                    dif.dec.first_rf = AEDEC_RF_ADDR;
                end
                default: begin
                    // Opmodes 4..6 belong to forms outside this decoder
                    dif.dec.use_ea  = 1'b0;
                    dif.dec.illegal = 1'b1;
                end
            endcase
        end else begin
            dif.dec.illegal = 1'b1;
        end
        dif.dec.valid = (dif.dec.op != AEDEC_OP_NONE);
    end
endmodule : aedec_table
`default_nettype wire

// File: logic/aedec_pkg.sv
// Package: opcode field layout, encodings and decoded operation types for the arithmetic/exchange decoder
`default_nettype none
package aedec_pkg;
    localparam int          AEDEC_OPW          = 16;
    localparam int          AEDEC_LINE_HI      = 15;
    localparam int          AEDEC_LINE_LO      = 12;
    localparam int          AEDEC_RX_HI        = 11;
    localparam int          AEDEC_RX_LO        = 9;
    localparam int          AEDEC_OPM_HI       = 8;
    localparam int          AEDEC_OPM_LO       = 6;
    localparam int          AEDEC_TYPE_BIT     = 8;
    localparam int          AEDEC_RM_BIT       = 3;
    localparam int          AEDEC_SRC_HI       = 2;
    localparam int          AEDEC_SRC_LO       = 0;
    localparam int          AEDEC_EAM_HI       = 5;
    localparam int          AEDEC_EAM_LO       = 3;
    localparam logic [3:0]  AEDEC_LINE_MUL     = 4'hC;
    localparam logic [3:0]  AEDEC_LINE_ADD     = 4'hD;
    localparam logic [1:0]  AEDEC_MUL_SEL      = 2'h3;
    localparam logic [4:0]  AEDEC_DADD_SEL     = 5'h10;
    // Swap selectors are opcode bits 8 down to 3
    localparam logic [5:0]  AEDEC_SWAP_DD      = 6'h28;
    localparam logic [5:0]  AEDEC_SWAP_AA      = 6'h29;
    localparam logic [5:0]  AEDEC_SWAP_DA      = 6'h31;
    localparam logic [2:0]  AEDEC_OPM_ADD_B    = 3'h0;
    localparam logic [2:0]  AEDEC_OPM_ADD_W    = 3'h1;
    localparam logic [2:0]  AEDEC_OPM_ADD_L    = 3'h2;
    localparam logic [2:0]  AEDEC_OPM_ADD_AN_W = 3'h3;
    localparam logic [2:0]  AEDEC_OPM_ADD_AN_L = 3'h7;
    localparam logic        AEDEC_TYPE_UNSIGN  = 1'b0;
    localparam logic        AEDEC_RM_REG       = 1'b0;

    typedef enum logic [3:0] {
        AEDEC_OP_NONE     = 4'h0,
        AEDEC_OP_UMUL_W   = 4'h1,
        AEDEC_OP_SMUL_W   = 4'h2,
        AEDEC_OP_DADD_REG = 4'h3,
        AEDEC_OP_DADD_MEM = 4'h4,
        AEDEC_OP_SWAP_DD  = 4'h5,
        AEDEC_OP_SWAP_AA  = 4'h6,
        AEDEC_OP_SWAP_DA  = 4'h7,
        AEDEC_OP_ADD_DN   = 4'h8,
        AEDEC_OP_ADD_AN   = 4'h9
    } aedec_op_t;

    typedef enum logic [1:0] {
        AEDEC_SZ_BYTE = 2'h0,
        AEDEC_SZ_WORD = 2'h1,
        AEDEC_SZ_LONG = 2'h2
    } aedec_size_t;

    // Register file selector for an operand
    typedef enum logic [1:0] {
        AEDEC_RF_NONE = 2'h0,
        AEDEC_RF_DATA = 2'h1,
        AEDEC_RF_ADDR = 2'h2
    } aedec_rf_t;

    typedef struct packed {
        logic        valid;
        aedec_op_t   op;
        aedec_size_t size;
        aedec_rf_t   first_rf;
        logic [2:0]  first_reg;
        aedec_rf_t   second_rf;
        logic [2:0]  second_reg;
        logic        predec;
        logic        use_ea;
        logic [5:0]  ea;
        logic        illegal;
    } aedec_dec_t;
endpackage : aedec_pkg
`default_nettype wire

// File: logic/aedec_if.sv
// Interface carrying the opcode word and combinational decode between decoder modules
`timescale 1ns/1ps
`default_nettype none
interface aedec_if;
    import aedec_pkg::*;
    logic [AEDEC_OPW-1:0] opcode;
    aedec_dec_t           dec;
    modport core  (output opcode, input dec);
    modport table_side (input opcode, output dec);
endinterface : aedec_if
`default_nettype wire

// File: logic/aedec_top.sv
// Registered opcode decoder for multiply, decimal add, register swap and add groups
// Overview of operation
// - Multiply type bit zero gives unsigned multiply, one gives signed multiply.
// - Decimal add select bit zero means register form, one means memory form.
// - Register form: both three-bit fields name data registers.
// - Memory form: both fields name address registers, both operands predecremented.
// - Data-with-address swap is a separate form from data-data and address-address.
`timescale 1ns/1ps
`default_nettype none
module aedec_top (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    // From fetch
    input  wire logic                        op_valid,
    input  wire logic [aedec_pkg::AEDEC_OPW-1:0] op_word,
    // To execute
    output logic                             dec_valid,
    output aedec_pkg::aedec_op_t             dec_op,
    output aedec_pkg::aedec_size_t           dec_size,
    output aedec_pkg::aedec_rf_t             dec_first_rf,
    output logic [2:0]                       dec_first_reg,
    output aedec_pkg::aedec_rf_t             dec_second_rf,
    output logic [2:0]                       dec_second_reg,
    output logic                             dec_predec,
    output logic                             dec_use_ea,
    output logic [5:0]                       dec_ea,
    output logic                             dec_illegal
);
    import aedec_pkg::*;

    typedef struct packed {
        aedec_dec_t dec;
    } aedec_state_t;

    aedec_state_t st_r;
    aedec_state_t st_nxt;
    aedec_if      dif ();

    assign dif.opcode = op_word;

    aedec_table u_table (
        .dif (dif.table_side)
    );

    // One cycle of latency keeps decode off the fetch-to-execute timing path
    always_comb begin
        st_nxt     = '0;
        st_nxt.dec = dif.dec;
        if (!op_valid) begin
            st_nxt.dec = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dec_valid      = st_r.dec.valid;
    assign dec_op         = st_r.dec.op;
    assign dec_size       = st_r.dec.size;
    assign dec_first_rf   = st_r.dec.first_rf;
    assign dec_first_reg  = st_r.dec.first_reg;
    assign dec_second_rf  = st_r.dec.second_rf;
    assign dec_second_reg = st_r.dec.second_reg;
    assign dec_predec     = st_r.dec.predec;
    assign dec_use_ea     = st_r.dec.use_ea;
    assign dec_ea         = st_r.dec.ea;
    assign dec_illegal    = st_r.dec.illegal;
endmodule : aedec_top
`default_nettype wire

// File: testbench/aedec_fetch_model.sv
// Fetch stage model handing opcode words to the decoder
`timescale 1ns/1ps
`default_nettype none
module aedec_fetch_model (
    // Clock
    input  wire logic        clk_sys,
    // Toward decoder
    output var  logic        op_valid,
    output var  logic [15:0] op_word
);
    initial begin
        op_valid = 1'b0;
        op_word  = 16'h0000;
    end
    // Words change at the falling edge so the decoder samples settled values
    task automatic send(input logic v, input logic [15:0] w);
        @(negedge clk_sys);
        op_valid = v;
        op_word  = w;
    endtask : send
endmodule : aedec_fetch_model
`default_nettype wire

// File: testbench/aedec_properties.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module aedec_properties (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    arst_n,
    // Fetch side
    input  wire logic                    op_valid,
    input  wire logic [15:0]             op_word,
    // Execute side
    input  wire logic                    dec_valid,
    input  wire aedec_pkg::aedec_op_t    dec_op,
    input  wire aedec_pkg::aedec_size_t  dec_size,
    input  wire aedec_pkg::aedec_rf_t    dec_first_rf,
    input  wire aedec_pkg::aedec_rf_t    dec_second_rf,
    input  wire logic                    dec_predec,
    input  wire logic                    dec_illegal
);
    import aedec_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire line_c = op_valid && op_word[15:12] == 4'hC;
    wire line_d = op_valid && op_word[15:12] == 4'hD;
    chk_mul_type_sel: assert property (line_c && op_word[7:6] == 2'h3 |=>
        dec_op == ($past(op_word[8]) ? AEDEC_OP_SMUL_W : AEDEC_OP_UMUL_W)) else $error("multiply type wrong");
    chk_dadd_form_sel: assert property (line_c && op_word[8:4] == 5'h10 |=>
        dec_op == ($past(op_word[3]) ? AEDEC_OP_DADD_MEM : AEDEC_OP_DADD_REG)) else $error("dadd form wrong");
    chk_dadd_data_regs: assert property (line_c && op_word[8:3] == 6'h20 |=>
        dec_first_rf == AEDEC_RF_DATA && dec_second_rf == AEDEC_RF_DATA && !dec_predec) else $error("dadd reg");
    chk_dadd_addr_predec: assert property (line_c && op_word[8:3] == 6'h21 |=>
        dec_first_rf == AEDEC_RF_ADDR && dec_second_rf == AEDEC_RF_ADDR && dec_predec) else $error("dadd mem");
    chk_swap_mixed_form: assert property (line_c && op_word[8:3] == 6'h31 |=>
        dec_op == AEDEC_OP_SWAP_DA && dec_second_rf == AEDEC_RF_ADDR) else $error("mixed swap wrong");
    chk_swap_same_form: assert property (line_c && op_word[8:4] == 5'h14 |=>
        dec_valid && dec_op == ($past(op_word[3]) ? AEDEC_OP_SWAP_AA : AEDEC_OP_SWAP_DD)) else $error("same-file swap wrong");
    chk_add_to_address_route: assert property (line_d && op_word[7:6] == 2'h3 |=>
        dec_op == AEDEC_OP_ADD_AN && dec_first_rf == AEDEC_RF_ADDR) else $error("add to address wrong");
    chk_add_dn_size: assert property (line_d && !op_word[8] && op_word[7:6] != 2'h3 |=>
        dec_op == AEDEC_OP_ADD_DN && dec_size == $past(op_word[7:6])) else $error("add size wrong");
    chk_idle_quiet: assert property (!op_valid |=> !dec_valid && !dec_illegal) else $error("idle output");
endmodule : aedec_properties
bind aedec_top aedec_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid), .op_word(op_word),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_size(dec_size), .dec_first_rf(dec_first_rf),
    .dec_second_rf(dec_second_rf), .dec_predec(dec_predec), .dec_illegal(dec_illegal));
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench comparing the decoder with a reference decode
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import aedec_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic op_valid;
    logic [15:0] op_word;
    aedec_dec_t seen;
    int err_total = 0;
    int checks = 0;
    logic [15:0] tbl [15] = '{16'hC0C0, 16'hC1C0, 16'hC300, 16'hC109, 16'hC14B, 16'hC94A, 16'hC78D, 16'hC540,
                             16'hD000, 16'hD240, 16'hD080, 16'hD0C0, 16'hD1C0, 16'hD100, 16'h4E71};
    initial forever #12.5 clk_sys = ~clk_sys;
    aedec_fetch_model fetch (.clk_sys(clk_sys), .op_valid(op_valid), .op_word(op_word));
    aedec_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid), .op_word(op_word),
        .dec_valid(seen.valid), .dec_op(seen.op), .dec_size(seen.size), .dec_first_rf(seen.first_rf),
        .dec_first_reg(seen.first_reg), .dec_second_rf(seen.second_rf), .dec_second_reg(seen.second_reg),
        .dec_predec(seen.predec), .dec_use_ea(seen.use_ea), .dec_ea(seen.ea), .dec_illegal(seen.illegal));
    function automatic aedec_dec_t model(input logic v, input logic [15:0] w);
        aedec_dec_t e;
        logic c;
        e = '0;
        c = w[15:12] == 4'hC;
        if (!v) return e;
        e.first_reg = w[11:9];
        e.second_reg = w[2:0];
        e.ea = w[5:0];
        if (c && w[7:6] == 2'h3) begin
            e.op = w[8] ? AEDEC_OP_SMUL_W : AEDEC_OP_UMUL_W;
            {e.size, e.first_rf, e.use_ea} = {AEDEC_SZ_WORD, AEDEC_RF_DATA, 1'b1};
        end else if (c && w[8:4] == 5'h10) begin
            e.op = w[3] ? AEDEC_OP_DADD_MEM : AEDEC_OP_DADD_REG;
            e.first_rf = w[3] ? AEDEC_RF_ADDR : AEDEC_RF_DATA;
            {e.second_rf, e.predec} = {e.first_rf, w[3]};
        end else if (c && w[8:3] inside {6'h28, 6'h29, 6'h31}) begin
            e.size = AEDEC_SZ_LONG;
            e.op = w[7] ? AEDEC_OP_SWAP_DA : (w[3] ? AEDEC_OP_SWAP_AA : AEDEC_OP_SWAP_DD);
            e.first_rf = (w[3] && !w[7]) ? AEDEC_RF_ADDR : AEDEC_RF_DATA;
            e.second_rf = w[3] ? AEDEC_RF_ADDR : AEDEC_RF_DATA;
        end else if (w[15:12] == 4'hD && (w[7:6] == 2'h3 || !w[8])) begin
            e.op = (w[7:6] == 2'h3) ? AEDEC_OP_ADD_AN : AEDEC_OP_ADD_DN;
            e.first_rf = (w[7:6] == 2'h3) ? AEDEC_RF_ADDR : AEDEC_RF_DATA;
            e.size = (w[7:6] == 2'h3) ? (w[8] ? AEDEC_SZ_LONG : AEDEC_SZ_WORD) : aedec_size_t'(w[7:6]);
            e.use_ea = 1'b1;
        end
        e.valid = e.op != AEDEC_OP_NONE;
        e.illegal = !e.valid;
        return e;
    endfunction : model
    task automatic cmp(input aedec_dec_t e);
        aedec_dec_t s;
        s = seen;
        // Fields outside the decoded group carry no promised value
        if (e.illegal) begin
            s         = '0;
            s.valid   = seen.valid;
            s.op      = seen.op;
            s.illegal = seen.illegal;
            e         = '0;
            e.illegal = 1'b1;
        end
        if (!e.use_ea) s.ea = e.ea;
        checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] decode expected %h seen %h", e, s);
        end
    endtask : cmp
    task automatic step(input logic v, input logic [15:0] w);
        fetch.send(v, w);
        @(posedge clk_sys);
        #1;
        cmp(model(v, w));
    endtask : step
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        #(5000 * 25);
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h9681705e));
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys) arst_n = 1'b1;
        foreach (tbl[i]) step(1'b1, tbl[i]);
        step(1'b0, 16'h3E8F);
        repeat (300) step(($urandom % 4) != 0, {3'h6, 1'($urandom), 12'($urandom)});
        @(negedge clk_sys) arst_n = 1'b0;
        #1 cmp(model(1'b0, 16'h0000));
        @(negedge clk_sys) arst_n = 1'b1;
        step(1'b1, 16'hC58F);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
